// >>> eeprom_link_pkg.sv
// shared constants for the two-wire memory link
package eeprom_link_pkg;
    localparam int          MEM_DEPTH      = 512;
    localparam int          ADDR_W         = 9;
    localparam int          PAGE_BYTES     = 16;
    localparam int          PAGE_W         = 4;
    localparam logic [3:0]  DEV_TYPE_ID    = 4'h5; // type prefix, arbitrary
    localparam int          CLK_MHZ        = 100;
    localparam int          WRITE_TIME_US  = 50;   // nonvolatile_write_time
    localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
    localparam int          SCL_HALF       = 8;    // host divider, sys clocks
    localparam int          MEM_INIT       = 8'hFF;
endpackage

// >>> eeprom_link_if.sv
// two-wire bus carrier with open-drain resolution
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
    logic scl_out;
    logic scl_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_s_out;
    logic sda_s_oe_n;
    logic scl;
    logic sda;
    // wired-and with pull-ups; enables are low while driving
    assign scl = scl_oe_n ? 1'b1 : scl_out;
    assign sda = (sda_m_oe_n ? 1'b1 : sda_m_out) &
                 (sda_s_oe_n ? 1'b1 : sda_s_out);
    modport device (input scl, input sda, output sda_s_out,
                    output sda_s_oe_n);
    modport host (input scl, input sda, output scl_out, output scl_oe_n,
                  output sda_m_out, output sda_m_oe_n);
endinterface
`default_nettype wire

// >>> eeprom_slave.sv
// slave end: two-wire front end of a 512 byte memory
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: 512 bytes reached only over the bus
// RULE2: slave only, never drives a start
// RULE3: data change with clock high is start/stop
// RULE4: transmitter releases data, receiver acks ninth
// RULE5: ack address match and every written byte
// RULE6: master sends type, then both select pins
// RULE7: seventh bit is address bit eight
// RULE8: last address bit one reads, zero writes
// RULE9: read ack continues, nack waits for stop
// RULE10: byte write commits on stop
// RULE11: busy writing means no ack at all
// RULE12: page takes sixteen bytes, one commit
// RULE13: page wraps low bits, overwrites earlier
// RULE14: counter holds last access plus one
// RULE15: master nacks then stops single read
// RULE16: random read loads address then restarts
// RULE17: sequential read increments and wraps fully
// RULE18: reset clears address pointer to zero
// RULE19: write time is a parameter, nack meanwhile
module eeprom_slave
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // straps
    input  wire logic          chip_select_high_pin,
    input  wire logic          chip_select_low_pin,
    // bus
    eeprom_link_if.device      bus,
    // status
    output logic               write_busy
);
    typedef enum {S_IDLE, S_DEV, S_DEV_ACK, S_WADDR, S_WADDR_ACK,
                  S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK, S_WAIT} state_t;

    // synchronisers and edge detection
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_p_q, sda_p_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.scl};
            sda_s_q <= {sda_s_q[0], bus.sda};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end
    wire scl_r = scl_s_q[1] & ~scl_p_q;
    wire scl_f = ~scl_s_q[1] & scl_p_q;
    // RULE3: start and stop
    wire start_c = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    wire stop_c  = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

    // RULE1: byte storage array
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pv_q, pv_d;

    state_t                 st_q, st_d;
    logic [7:0]             sh_q, sh_d;
    logic [3:0]             cnt_q, cnt_d;
    logic [ADDR_W-1:0]      ad_q, ad_d;
    logic                   blk_q, blk_d;
    logic                   drv_q, drv_d;
    logic                   ack_q, ack_d;
    logic                   sda_oe_n_q;     // registered pin enable
    logic [31:0]            wt_q, wt_d;
    logic                   pg_we;
    logic                   commit;

    // next state of the protocol engine
    always_comb begin
        st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; ad_d = ad_q;
        blk_d = blk_q; drv_d = drv_q; ack_d = ack_q; wt_d = wt_q;
        pv_d = pv_q; pg_we = 1'b0; commit = 1'b0;
        if (wt_q != 32'h0) begin
            // RULE11: inputs ignored while writing
            // RULE19: hold off for the write time
            wt_d = wt_q - 32'h1;
            st_d = S_IDLE; drv_d = 1'b0;
        end else if (start_c) begin
            st_d = S_DEV; cnt_d = 4'h0; drv_d = 1'b0;
        end else if (stop_c) begin
            drv_d = 1'b0; st_d = S_IDLE;
            // RULE10: commit on stop
            // RULE12: one cycle for whole page
            if (pv_q != '0) begin
                commit = 1'b1;
                wt_d = 32'(WRITE_CYC);
                pv_d = '0;
            end
        end else begin
            case (st_q)
                S_DEV, S_WADDR, S_WDATA: begin
                    if (scl_r) begin
                        sh_d = {sh_q[6:0], sda_s_q[1]};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_f && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        ack_d = 1'b1;
                        case (st_q)
                            S_DEV: begin
                                // RULE6: type and select match
                                if (sh_q[7:4] == DEV_TYPE_ID &&
                                    sh_q[3] == chip_select_high_pin &&
                                    sh_q[2] == chip_select_low_pin) begin
                                    // RULE5: ack the address
                                    drv_d = 1'b1;
                                    blk_d = sh_q[1]; // RULE7: block bit
                                    st_d = S_DEV_ACK;
                                end else begin
                                    st_d = S_IDLE;
                                end
                            end
                            S_WADDR: begin
                                // RULE16: load word address
                                ad_d = {blk_q, sh_q};
                                drv_d = 1'b1; st_d = S_WADDR_ACK;
                            end
                            default: begin
                                // RULE13: low bits wrap in page
                                pg_we = 1'b1;
                                pv_d[ad_q[PAGE_W-1:0]] = 1'b1;
                                ad_d = {ad_q[ADDR_W-1:PAGE_W],
                                        ad_q[PAGE_W-1:0] + 4'h1};
                                drv_d = 1'b1; st_d = S_WDATA_ACK;
                            end
                        endcase
                    end
                end
                S_DEV_ACK: if (scl_f) begin
                    // RULE8: direction bit
                    if (sh_q[0]) begin
                        // RULE14: read at counter
                        sh_d = mem_q[ad_q];
                        ad_d = ad_q + 9'h1;
                        drv_d = ~mem_q[ad_q][7] ? 1'b1 : 1'b0;
                        ack_d = 1'b0; cnt_d = 4'h1;
                        st_d = S_RDATA;
                    end else begin
                        drv_d = 1'b0; st_d = S_WADDR;
                    end
                end
                S_WADDR_ACK, S_WDATA_ACK: if (scl_f) begin
                    drv_d = 1'b0; st_d = S_WDATA;
                end
                S_RDATA: if (scl_f) begin
                    if (cnt_q == 4'h8) begin
                        // RULE4: release for master ack
                        drv_d = 1'b0; st_d = S_RACK;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b1};
                        drv_d = ~sh_q[6];
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                S_RACK: begin
                    if (scl_r) ack_d = ~sda_s_q[1];
                    if (scl_f) begin
                        // RULE9: continue or wait stop
                        if (ack_q) begin
                            // RULE17: full counter wraps
                            sh_d = mem_q[ad_q];
                            ad_d = ad_q + 9'h1;
                            drv_d = ~mem_q[ad_q][7];
                            cnt_d = 4'h1; st_d = S_RDATA;
                        end else begin
                            st_d = S_WAIT;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // protocol registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q <= S_IDLE; sh_q <= 8'h00; cnt_q <= 4'h0;
            // RULE18: pointer cleared
            ad_q <= 9'h000;
            blk_q <= 1'b0; drv_q <= 1'b0; ack_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            wt_q <= 32'h0; pv_q <= '0; write_busy <= 1'b0;
        end else begin
            st_q <= st_d; sh_q <= sh_d; cnt_q <= cnt_d; ad_q <= ad_d;
            blk_q <= blk_d; drv_q <= drv_d; ack_q <= ack_d;
            sda_oe_n_q <= ~drv_d;
            wt_q <= wt_d; pv_q <= pv_d; write_busy <= (wt_d != 32'h0);
        end
    end

    // page buffer and array commit
    always_ff @(posedge clk_sys) begin
        if (pg_we) page_q[ad_q[PAGE_W-1:0]] <= sh_q;
    end
    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge clk_sys) begin
            if (!rstn) mem_q[i] <= 8'(MEM_INIT);
            else if (commit && pv_q[i % PAGE_BYTES] &&
                     (i / PAGE_BYTES) == int'(ad_q[ADDR_W-1:PAGE_W]))
                mem_q[i] <= page_q[i % PAGE_BYTES];
        end
    end

    // RULE2: data line only pulled low, never scl
    assign bus.sda_s_out  = 1'b0;
    assign bus.sda_s_oe_n = sda_oe_n_q;
endmodule
`default_nettype wire

// >>> eeprom_master.sv
// master end: drives clock and issues byte transfers
`timescale 1ns/1ps
`default_nettype none
module eeprom_master
    import eeprom_link_pkg::*;
#(
    parameter int HALF = SCL_HALF
) (
    // clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rstn,
    // user request: op 0 start, 1 byte, 2 stop
    input  wire logic       req_valid,
    input  wire logic [1:0] req_op,
    input  wire logic [7:0] req_wdata,
    input  wire logic       req_read,
    input  wire logic       req_ack,
    output logic            req_ready,
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    output logic            rsp_acked,
    // bus
    eeprom_link_if.host     bus
);
    typedef enum {M_IDLE, M_RUN} mstate_t;
    logic [1:0] sda_s_q;
    mstate_t    st_q, st_d;
    logic [1:0] op_q, op_d;
    logic [5:0] ph_q, ph_d;    // quarter phases
    logic [7:0] dv_q, dv_d;
    logic [8:0] sh_q, sh_d;
    logic [8:0] rx_q, rx_d;
    logic       scl_q, scl_d, sda_q, sda_d;
    logic       rv_d;

    // sample data line, two flops
    always_ff @(posedge clk_sys) begin
        if (!rstn) sda_s_q <= 2'h3;
        else sda_s_q <= {sda_s_q[0], bus.sda};
    end

    // next values: each op runs in quarter-bit phases
    always_comb begin
        st_d = st_q; op_d = op_q; ph_d = ph_q; dv_d = dv_q;
        sh_d = sh_q; rx_d = rx_q; scl_d = scl_q; sda_d = sda_q;
        rv_d = 1'b0;
        case (st_q)
            M_IDLE: if (req_valid) begin
                st_d = M_RUN; op_d = req_op; ph_d = 6'h0; dv_d = 8'h0;
                // RULE4: release for read data or ack slot
                sh_d = {req_read ? 8'hFF : req_wdata,
                        req_read ? ~req_ack : 1'b1};
            end
            default: begin
                dv_d = dv_q + 8'h1;
                if (dv_q == 8'(HALF/2 - 1)) begin
                    dv_d = 8'h0;
                    ph_d = ph_q + 6'h1;
                    case (op_q)
                        2'h0: begin // RULE3: start, sda falls, scl high
                            case (ph_q[1:0])
                                2'h0: begin sda_d = 1'b1; end
                                2'h1: scl_d = 1'b1;
                                2'h2: sda_d = 1'b0;
                                default: begin
                                    scl_d = 1'b0; st_d = M_IDLE;
                                    rv_d = 1'b1;
                                end
                            endcase
                        end
                        2'h2: begin // stop, sda rises, scl high
                            case (ph_q[1:0])
                                2'h0: sda_d = 1'b0;
                                2'h1: scl_d = 1'b1;
                                2'h2: sda_d = 1'b1;
                                default: begin
                                    st_d = M_IDLE; rv_d = 1'b1;
                                end
                            endcase
                        end
                        default: begin // nine bits
                            case (ph_q[1:0])
                                2'h0: sda_d = sh_q[8];
                                2'h1: scl_d = 1'b1;
                                2'h2: rx_d = {rx_q[7:0], sda_s_q[1]};
                                default: begin
                                    scl_d = 1'b0;
                                    sh_d = {sh_q[7:0], 1'b1};
                                    if (ph_q[5:2] == 4'h8) begin
                                        st_d = M_IDLE; rv_d = 1'b1;
                                    end
                                end
                            endcase
                        end
                    endcase
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q <= M_IDLE; op_q <= 2'h0; ph_q <= 6'h0; dv_q <= 8'h0;
            sh_q <= 9'h1FF; rx_q <= 9'h0; scl_q <= 1'b1; sda_q <= 1'b1;
            req_ready <= 1'b0; rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00; rsp_acked <= 1'b0;
        end else begin
            st_q <= st_d; op_q <= op_d; ph_q <= ph_d; dv_q <= dv_d;
            sh_q <= sh_d; rx_q <= rx_d; scl_q <= scl_d; sda_q <= sda_d;
            req_ready <= (st_d == M_IDLE) && !(st_q == M_IDLE && req_valid);
            rsp_valid <= rv_d;
            if (rv_d) begin
                rsp_rdata <= rx_d[8:1];
                rsp_acked <= ~rx_d[0];
            end
        end
    end

    // open-drain drive: enable low pulls the line low
    assign bus.scl_out    = 1'b0;
    assign bus.scl_oe_n   = scl_q;
    assign bus.sda_m_out  = 1'b0;
    assign bus.sda_m_oe_n = sda_q;
endmodule
`default_nettype wire

// >>> eeprom_link_checker.sv
// assertions on the shared two-wire lines and the write status
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_checker
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // lines and status
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe_n,
    input wire logic write_busy
);
    int busy_d;
    int busy_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // cycles spent in the current write time
    always_comb busy_d = write_busy ? busy_q + 1 : 0;
    always_ff @(posedge clk_sys) busy_q <= rstn ? busy_d : 0;
    chk_drive_clock_low: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("slave data changed while clock high");
    chk_never_starts: assert property (($fell(sda) && scl && $past(scl))
        |-> sda_s_oe_n) else $error("slave made a start");
    chk_busy_no_ack: assert property (write_busy |-> sda_s_oe_n)
        else $error("slave drove data while writing");
    chk_busy_length: assert property ($fell(write_busy) |->
        (busy_q >= WRITE_CYC - 1 && busy_q <= WRITE_CYC + 1))
        else $error("write time has the wrong length");
    chk_busy_holds: assert property ($rose(write_busy) |=> write_busy[*8])
        else $error("write time ended early");
    chk_commit_on_stop: assert property ($rose(write_busy) |-> scl && sda)
        else $error("write began without a stop");
    chk_release_at_stop: assert property (($rose(sda) && scl && $past(scl))
        |-> sda_s_oe_n[*4]) else $error("slave drove data after stop");
    chk_single_commit: assert property ($fell(write_busy) |-> !write_busy[*8])
        else $error("second write time without a transfer");
endmodule
`default_nettype wire

// >>> tb_serial_eeprom_slave.sv
// self-checking bench joining master and slave ends over one link
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_slave;
    import eeprom_link_pkg::*;
    localparam int WCYC = 400;
    localparam int RUN_CYCLES = 40000;  // about three times the tests
    logic              clk_sys;
    logic              rstn;
    logic              cs_hi;
    logic              cs_lo;
    logic              req_valid;
    logic [1:0]        req_op;
    logic [7:0]        req_wdata;
    logic              req_read;
    logic              req_ack;
    logic              req_ready;
    logic              rsp_valid;
    logic [7:0]        rsp_rdata;
    logic              rsp_acked;
    logic              write_busy;
    logic [7:0]        mem [MEM_DEPTH];
    int                fail_count;
    int                total_checks;
    int                seed;
    logic [ADDR_W-1:0] a;
    logic [7:0]        d;
    eeprom_link_if link ();
    eeprom_slave #(.WRITE_CYC(WCYC)) eeprom_slave_i (.clk_sys(clk_sys),
        .rstn(rstn), .chip_select_high_pin(cs_hi),
        .chip_select_low_pin(cs_lo), .bus(link.device),
        .write_busy(write_busy));
    eeprom_master eeprom_master_i (.clk_sys(clk_sys), .rstn(rstn),
        .req_valid(req_valid), .req_op(req_op), .req_wdata(req_wdata),
        .req_read(req_read), .req_ack(req_ack), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_acked(rsp_acked), .bus(link.host));
    eeprom_link_checker #(.WRITE_CYC(WCYC)) eeprom_link_checker_i (
        .clk_sys(clk_sys), .rstn(rstn), .scl(link.scl), .sda(link.sda),
        .sda_s_oe_n(link.sda_s_oe_n), .write_busy(write_busy));
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check8(input string n, input logic [7:0] e,
                          input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask
    // page slot that the j-th byte from s lands in, low bits wrap
    function automatic logic [ADDR_W-1:0] slot(input logic [ADDR_W-1:0] s,
                                               input int j);
        return {s[8:4], 4'(s[3:0] + j)};
    endfunction
    // one master request, held until taken, then wait for its answer
    task automatic op(input logic [1:0] o, input logic [7:0] wd,
                      input logic rd, input logic ak);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (req_ready !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 1000) fail_count++;
        req_valid = 1'b1;
        req_op = o;
        req_wdata = wd;
        req_read = rd;
        req_ack = ak;
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 1000) fail_count++;
    endtask
    // start then slave address byte built from straps, block and mode
    task automatic sel(input logic [1:0] cs, input logic b, input logic r);
        op(2'd0, 8'h00, 1'b0, 1'b0);
        op(2'd1, {DEV_TYPE_ID, cs, b, r}, 1'b0, 1'b0);
    endtask
    // current address read of one byte, nacked and then stopped
    task automatic rd_cur(input logic [ADDR_W-1:0] p);
        sel({cs_hi, cs_lo}, 1'b0, 1'b1);
        check1("current read ack", 1'b1, rsp_acked);
        op(2'd1, 8'hFF, 1'b1, 1'b0);
        check8("current read", mem[p], rsp_rdata);
        op(2'd2, 8'h00, 1'b0, 1'b0);
    endtask
    // random read of cnt bytes, acking all but the last
    task automatic rd_seq(input logic [ADDR_W-1:0] s, input int cnt);
        logic [ADDR_W-1:0] p;
        p = s;
        sel({cs_hi, cs_lo}, s[8], 1'b0);
        op(2'd1, s[7:0], 1'b0, 1'b0);
        sel({cs_hi, cs_lo}, s[8], 1'b1);
        check1("read select ack", 1'b1, rsp_acked);
        for (int j = 0; j < cnt; j++) begin
            op(2'd1, 8'hFF, 1'b1, j < cnt - 1);
            check8("read data", mem[p], rsp_rdata);
            p = p + 1'b1;
        end
        // after the nack the slave must not begin another byte
        repeat (8) @(negedge clk_sys);
        check1("line released", 1'b1, link.sda_s_oe_n);
        op(2'd2, 8'h00, 1'b0, 1'b0);
    endtask
    // write bytes from address s, then stop and wait out the write time
    task automatic wr(input logic [ADDR_W-1:0] s, input int cnt);
        int n;
        sel({cs_hi, cs_lo}, s[8], 1'b0);
        check1("write select ack", 1'b1, rsp_acked);
        op(2'd1, s[7:0], 1'b0, 1'b0);
        check1("word address ack", 1'b1, rsp_acked);
        for (int j = 0; j < cnt; j++) begin
            d = 8'($urandom);
            op(2'd1, d, 1'b0, 1'b0);
            check1("data ack", 1'b1, rsp_acked);
            mem[slot(s, j)] = d;
        end
        op(2'd2, 8'h00, 1'b0, 1'b0);
        check1("busy after stop", 1'b1, write_busy);
        sel({cs_hi, cs_lo}, s[8], 1'b0);
        check1("poll while busy", 1'b0, rsp_acked);
        op(2'd2, 8'h00, 1'b0, 1'b0);
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC * 2) begin
            @(negedge clk_sys);
            n++;
        end
        check1("busy ended", 1'b0, write_busy);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog against a hung transfer
    initial begin
        #(RUN_CYCLES * 10);
        fail_count++;
        finish_test();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_op = 2'd0;
        req_wdata = 8'h00;
        req_read = 1'b0;
        req_ack = 1'b0;
        fail_count = 0;
        total_checks = 0;
        seed = $urandom(32'hc8dfc74d);
        cs_hi = 1'($urandom);
        cs_lo = 1'($urandom);
        foreach (mem[k]) mem[k] = 8'hFF;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        // current reads from the cleared pointer
        for (int k = 0; k < 2; k++) begin
            rd_cur(9'(k));
        end
        $display("test current read done");
        // other strap settings are not this device
        for (int k = 1; k < 4; k++) begin
            sel({cs_hi, cs_lo} ^ 2'(k), 1'b0, 1'b1);
            check1("other device", 1'b0, rsp_acked);
            op(2'd2, 8'h00, 1'b0, 1'b0);
        end
        // a wrong device type is not this device either
        op(2'd0, 8'h00, 1'b0, 1'b0);
        op(2'd1, {DEV_TYPE_ID ^ 4'h1, cs_hi, cs_lo, 2'h1}, 1'b0, 1'b0);
        check1("other type", 1'b0, rsp_acked);
        op(2'd2, 8'h00, 1'b0, 1'b0);
        $display("test select done");
        // byte writes in both blocks, then random read back
        for (int k = 0; k < 3; k++) begin
            a = {k[0], 8'($urandom_range(16, 239))}; // both blocks
            wr(a, 1);
            rd_seq(a, 1);
        end
        $display("test byte write done");
        // page write of seventeen bytes wraps inside the page
        a = 9'($urandom_range(2, 29) * PAGE_BYTES + 5);
        wr(a, 17);
        rd_seq({a[8:4], 4'h0}, PAGE_BYTES);
        rd_seq(a, 1);
        rd_cur(slot(a, 1));
        $display("test page write done");
        // sequential read rolls from the last location to zero
        rd_seq(9'h1FF, 3);
        $display("test roll over done");
        finish_test();
    end
endmodule
`default_nettype wire
